//--- hcb_pkg.sv
// hcb_pkg: constants for the host command interpreter (window, filter, baud, echo)
// assumes a byte stream already deframed by the UART/SPI front end
package hcb_pkg;
   localparam logic [7:0] CMD_PROTOCOL_CHOOSE = 8'h02;
   localparam logic [7:0] CMD_REGISTER_WRITE = 8'h09;
   localparam logic [7:0] CMD_BAUD = 8'h0a;
   localparam logic [7:0] CMD_ECHO = 8'h55;
   localparam logic [7:0] LEN_WR_SHORT = 8'h03;
   localparam logic [7:0] LEN_WR_LONG = 8'h04;
   localparam logic [7:0] LEN_BAUD = 8'h01;
   localparam logic [7:0] ADDR_DEMOD_SYNC_WINDOW = 8'h3a;
   localparam logic [7:0] ADDR_SYNC_FILTER = 8'h0a;
   localparam logic [7:0] WINDOW_CONFIRM = 8'h04;
   localparam logic [7:0] WINDOW_MIN = 8'h50;
   localparam logic [7:0] WINDOW_MAX = 8'h60;
   localparam logic [7:0] WINDOW_DEFAULT = 8'h52;
   localparam logic [7:0] FLAG_MAX = 8'h01;
   localparam logic [7:0] RESULT_OK = 8'h00;
   localparam logic [7:0] RESULT_LEN = 8'h00;
   localparam logic [7:0] RESULT_BAD = 8'h82;
   localparam logic [7:0] BAUD_REPLY = 8'h55;
   localparam logic [7:0] DIVISOR_RESET = 8'd117;
   localparam logic [7:0] DIVISOR_MIN = 8'd2;
   localparam logic [8:0] BIT_PERIOD_EXTRA = 9'd2;
   localparam int REF_CLK_KHZ = 13560;
   localparam int CLK_KHZ = 125000;
   typedef enum logic [7:0]
   {
      ST_IDLE = 8'h01,
      ST_LEN = 8'h02,
      ST_ADDR = 8'h04,
      ST_FLAG = 8'h08,
      ST_VALUE = 8'h10,
      ST_CONFIRM = 8'h20,
      ST_DIV = 8'h40,
      ST_SKIP = 8'h80
   } hcb_state_e;
   typedef enum logic [2:0]
   {
      RP_NONE = 3'b001,
      RP_TWO = 3'b010,
      RP_SECOND = 3'b100
   } hcb_reply_e;
endpackage

//--- hcb_baud_tick.sv
// hcb_baud_tick: bit-rate tick from the divisor, reference clock 13.56 MHz emulated
// assumes clk at 125 MHz; fractional accumulator keeps the average rate exact
`timescale 1ns/1ps
`default_nettype none
module hcb_baud_tick
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] divisor,
   output logic bit_tick
);
   import hcb_pkg::*;
   logic [31:0] acc_ff;
   logic [31:0] period;
   logic [7:0] last_div_ff;
   // one bit lasts (2*div+2) reference cycles; scale both sides to avoid division
   assign period = 32'(({1'b0, divisor} << 1) + BIT_PERIOD_EXTRA) * 32'(CLK_KHZ);
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         acc_ff <= '0;
         bit_tick <= 1'b0;
         last_div_ff <= DIVISOR_RESET;
      end
      else if (divisor != last_div_ff)
      begin
         // restart the period on a new divisor; the old remainder would burst ticks
         acc_ff <= '0;
         bit_tick <= 1'b0;
         last_div_ff <= divisor;
      end
      else if (acc_ff + 32'(REF_CLK_KHZ) >= period)
      begin
         acc_ff <= acc_ff + 32'(REF_CLK_KHZ) - period;
         bit_tick <= 1'b1;
      end
      else
      begin
         acc_ff <= acc_ff + 32'(REF_CLK_KHZ);
         bit_tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- hcb_host_cmd.sv
// hcb_host_cmd: interprets host command bytes for window, filter, baud and echo
// assumes rx bytes come from the serial front end on clk, one-cycle valid strobes
`timescale 1ns/1ps
`default_nettype none
module hcb_host_cmd
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic protocol_choose_command,
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] demod_sync_window,
   output logic sync_assist_filter,
   output logic [7:0] baud_divisor,
   output logic bit_tick
);
   import hcb_pkg::*;
   hcb_state_e state_ff;
   hcb_reply_e reply_ff;
   logic [7:0] cmd_ff;
   logic [7:0] written_register_count_ff;
   logic [7:0] addr_ff;
   logic [7:0] value_ff;
   logic [7:0] tx_data_ff;
   logic [7:0] second_ff;
   logic ok_ff;
   logic [7:0] window_ff;
   logic filter_ff;
   logic [7:0] div_ff;
   logic finish_write;
   logic write_ok;
   logic div_load;
   logic rate_switch_ff;
   logic reply_tick;

   function automatic logic window_in_range(input logic [7:0] v);
      return (v >= WINDOW_MIN) && (v <= WINDOW_MAX);
   endfunction

   // bytes arriving while a reply is pending are dropped; host waits for the answer
   // a bad length ends the frame after the value byte, so the host still gets an error
   assign finish_write = rx_valid && reply_ff == RP_NONE &&
      ((state_ff == ST_CONFIRM) ||
       (state_ff == ST_VALUE && written_register_count_ff != LEN_WR_LONG));
   // a write is good only with a sound frame, the confirm byte of a long frame and an in-range window
   assign write_ok = ok_ff &&
      (state_ff == ST_VALUE || rx_data == WINDOW_CONFIRM) &&
      (addr_ff != ADDR_DEMOD_SYNC_WINDOW ||
       window_in_range(state_ff == ST_VALUE ? rx_data : value_ff));
   assign div_load = rx_valid && reply_ff == RP_NONE && state_ff == ST_DIV && ok_ff &&
      rx_data >= DIVISOR_MIN;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state_ff <= ST_IDLE;
         cmd_ff <= '0;
         written_register_count_ff <= '0;
         addr_ff <= '0;
         value_ff <= '0;
         ok_ff <= 1'b0;
      end
      else if (rx_valid && reply_ff == RP_NONE)
      begin
         unique case (state_ff)
            ST_IDLE:
            begin
               cmd_ff <= rx_data;
               ok_ff <= 1'b1;
               if (rx_data == CMD_REGISTER_WRITE || rx_data == CMD_BAUD)
                  state_ff <= ST_LEN;
            end
            ST_LEN:
            begin
               written_register_count_ff <= rx_data;
               if (cmd_ff == CMD_BAUD)
               begin
                  ok_ff <= (rx_data == LEN_BAUD);
                  state_ff <= ST_DIV;
               end
               else
               begin
                  ok_ff <= (rx_data == LEN_WR_SHORT || rx_data == LEN_WR_LONG);
                  state_ff <= ST_ADDR;
               end
            end
            ST_ADDR:
            begin
               addr_ff <= rx_data;
               state_ff <= ST_FLAG;
            end
            ST_FLAG:
            begin
               if (rx_data > FLAG_MAX)
                  ok_ff <= 1'b0;
               state_ff <= ST_VALUE;
            end
            ST_VALUE:
            begin
               value_ff <= rx_data;
               state_ff <= (written_register_count_ff == LEN_WR_LONG) ? ST_CONFIRM : ST_IDLE;
            end
            ST_CONFIRM:
               state_ff <= ST_IDLE;
            ST_DIV:
               state_ff <= ST_IDLE;
            ST_SKIP:
               state_ff <= ST_IDLE;
         endcase
      end
   end

   // window register: protocol choose wins over a write landing in the same cycle
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         window_ff <= WINDOW_DEFAULT;
      else if (protocol_choose_command)
         window_ff <= WINDOW_DEFAULT;
      else if (finish_write && write_ok && addr_ff == ADDR_DEMOD_SYNC_WINDOW)
         window_ff <= (state_ff == ST_VALUE) ? rx_data : value_ff;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         filter_ff <= 1'b0;
      else if (protocol_choose_command)
         filter_ff <= 1'b0;
      else if (finish_write && write_ok && addr_ff == ADDR_SYNC_FILTER)
         filter_ff <= (state_ff == ST_VALUE) ? rx_data[0] : value_ff[0];
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         div_ff <= DIVISOR_RESET;
      else if (div_load)
         div_ff <= rx_data;
   end

   // the tick generator restarts one cycle after a new divisor; a tick still launched
   // at the old rate in that cycle must not carry the baud answer
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         rate_switch_ff <= 1'b0;
      else
         rate_switch_ff <= div_load;
   end

   // reply sequencer; the divisor is already updated when the baud answer starts
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         reply_ff <= RP_NONE;
         tx_data_ff <= '0;
         second_ff <= '0;
      end
      else
      begin
         unique case (reply_ff)
            RP_NONE:
            begin
               if (rx_valid && state_ff == ST_IDLE && rx_data == CMD_ECHO)
               begin
                  tx_data_ff <= CMD_ECHO;
                  reply_ff <= RP_SECOND;
               end
               else if (rx_valid && state_ff == ST_DIV)
               begin
                  tx_data_ff <= div_load ? BAUD_REPLY : RESULT_BAD;
                  second_ff <= RESULT_LEN;
                  reply_ff <= div_load ? RP_SECOND : RP_TWO;
               end
               else if (finish_write)
               begin
                  tx_data_ff <= write_ok ? RESULT_OK : RESULT_BAD;
                  second_ff <= RESULT_LEN;
                  reply_ff <= RP_TWO;
               end
            end
            RP_TWO:
               if (tx_ready && reply_tick)
               begin
                  tx_data_ff <= second_ff;
                  reply_ff <= RP_SECOND;
               end
            RP_SECOND:
               if (tx_ready && reply_tick)
                  reply_ff <= RP_NONE;
            default:
               reply_ff <= RP_NONE;
         endcase
      end
   end

   // bytes go out on a bit tick so the serialiser sees the current rate
   assign reply_tick = bit_tick && !rate_switch_ff;
   assign tx_valid = (reply_ff != RP_NONE) && reply_tick;
   assign tx_data = tx_data_ff;
   assign demod_sync_window = window_ff;
   assign sync_assist_filter = filter_ff;
   assign baud_divisor = div_ff;

   hcb_baud_tick u_tick
   (
      .clk(clk),
      .reset_n(reset_n),
      .divisor(div_ff),
      .bit_tick(bit_tick)
   );
endmodule
`default_nettype wire

//--- hcb_host_cmd_asserts.sv
// hcb_chk: port-level checks of the host command interpreter
// assumes it is bound onto hcb_host_cmd, one clock domain
`timescale 1ns/1ps
`default_nettype none
module hcb_chk
   import hcb_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic protocol_choose_command,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] demod_sync_window,
   input wire logic sync_assist_filter,
   input wire logic [7:0] baud_divisor,
   input wire logic bit_tick
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [15:0] gap_ff;
   logic full_ff;
   int lo;
   assign lo = (2 * int'(baud_divisor) + 2) * CLK_KHZ / REF_CLK_KHZ;
   always_ff @(posedge clk)
   begin
      if (!reset_n || bit_tick || $changed(baud_divisor))
         gap_ff <= 16'h0001;
      else
         gap_ff <= gap_ff + 16'h0001;
   end
   // a gap is judged only when the divisor held still for a whole period
   always_ff @(posedge clk)
   begin
      if (!reset_n || $changed(baud_divisor))
         full_ff <= 1'b0;
      else if (bit_tick)
         full_ff <= 1'b1;
   end
   sequence s_wr_frame;
      rx_valid && rx_data == 8'h09 ##1 rx_valid && rx_data == 8'h04
      ##1 rx_valid && rx_data == 8'h3a ##1 rx_valid && rx_data <= 8'h01
      ##1 rx_valid && rx_data inside {[8'h50:8'h60]} ##1 rx_valid && rx_data == 8'h04;
   endsequence
   a_pick_window: assert property (
      protocol_choose_command |=> demod_sync_window == 8'h52) else $error("window not reloaded");
   a_pick_filter: assert property (
      protocol_choose_command |=> !sync_assist_filter) else $error("filter left on");
   a_write_window: assert property (
      s_wr_frame |=> demod_sync_window == $past(rx_data, 2)) else $error("window not written");
   a_reset_div: assert property (
      $rose(reset_n) |-> baud_divisor == 8'd117) else $error("bad divisor after reset");
   a_div_cause: assert property (
      $changed(baud_divisor) |-> baud_divisor >= 8'd2 && ($past(rx_valid) || $past(rx_valid, 2)))
      else $error("divisor changed without cause");
   a_tick_gap: assert property (
      bit_tick && full_ff && $stable(baud_divisor) |-> gap_ff >= lo && gap_ff <= lo + 1)
      else $error("bit period wrong");
   a_offer_tick: assert property (
      tx_valid |-> bit_tick) else $error("reply off the bit tick");
   a_reply_hold: assert property (
      tx_valid && !tx_ready |=> $stable(tx_data)) else $error("reply byte dropped");
endmodule
`default_nettype wire

//--- hcb_host_model.sv
// hcb_host_model: host controller sending frames and collecting reply bytes
// assumes the interpreter takes one byte per rx_valid cycle
`timescale 1ns/1ps
`default_nettype none
module hcb_host_model
(
   input wire logic clk,
   input wire logic slow,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready
);
   logic [7:0] got_q[$];
   logic [3:0] ph = 4'h0;
   initial rx_data = 8'h00;
   initial rx_valid = 1'b0;
   initial tx_ready = 1'b1;
   // a slow host refuses half the time, so replies must be retried
   always @(posedge clk)
   begin
      ph <= ph + 4'h1;
      tx_ready <= !slow || ph[3];
      if (tx_valid && tx_ready)
         got_q.push_back(tx_data);
   end
   task automatic send(input logic [7:0] b[]);
      foreach (b[i])
      begin
         @(posedge clk);
         rx_valid <= 1'b1;
         rx_data <= b[i];
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~b[b.size() - 1];
   endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// tb_top: self-checking bench for the host command interpreter
// assumes hcb_host_model plays the host; the checker is bound at the foot
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic protocol_choose_command = 1'b0;
   logic slow = 1'b0;
   logic [7:0] rx_data, tx_data, demod_sync_window, baud_divisor, v, w;
   logic rx_valid, tx_valid, tx_ready, sync_assist_filter, bit_tick;
   logic [7:0] div_tab[4] = '{8'd2, 8'd1, 8'd0, 8'd3};
   int n_errors = 0;
   int cmp_count = 0;
   int seed = 32'hd4c6;
   int cyc;
   always #4 clk = ~clk;
   hcb_host_cmd dut_u (.clk(clk), .reset_n(reset_n), .rx_data(rx_data), .rx_valid(rx_valid),
      .protocol_choose_command(protocol_choose_command), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .demod_sync_window(demod_sync_window),
      .sync_assist_filter(sync_assist_filter), .baud_divisor(baud_divisor),
      .bit_tick(bit_tick));
   hcb_host_model host_u (.clk(clk), .slow(slow), .rx_data(rx_data), .rx_valid(rx_valid),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [7:0] wr_result(input logic [7:0] val);
      return (val >= 8'h50 && val <= 8'h60) ? 8'h00 : 8'h82;
   endfunction
   task automatic frame(input logic [7:0] b[], input int n);
      host_u.got_q.delete();
      host_u.send(b);
      for (cyc = 0; host_u.got_q.size() < n && cyc < 20000; cyc++)
         @(posedge clk);
      if (cyc >= 20000)
      begin
         $display("[ERR] %0t no reply from the interpreter", $time);
         n_errors++;
         conclude();
      end
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      #1;
      chk(baud_divisor, 8'd117);
      chk(demod_sync_window, 8'h52);
      frame('{8'h55}, 1);
      chk(host_u.got_q[0], 8'h55);
      $display("echo done");
      foreach (div_tab[i])
      begin
         v = baud_divisor;
         frame('{8'h0a, 8'h01, div_tab[i]}, div_tab[i] > 1 ? 1 : 2);
         chk(host_u.got_q[0], div_tab[i] > 1 ? 8'h55 : 8'h82);
         if (div_tab[i] < 2)
            chk(host_u.got_q[1], 8'h00);
         chk(baud_divisor, div_tab[i] > 1 ? div_tab[i] : v);
         // the old rate would need thousands of cycles for one byte
         if (i == 0)
            chk(cyc < 200 ? 8'h01 : 8'h00, 8'h01);
      end
      $display("baud done");
      slow <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         v = (i < 2) ? 8'h50 + 8'(i * 16) : 8'h4f + 8'($unsigned($random(seed)) % 19);
         if (i == 2)
            v = 8'h58;
         w = demod_sync_window;
         if (i % 3 == 1)
            frame('{8'h09, 8'h03, 8'h3a, 8'($random(seed) & 1), v}, 2);
         else
            frame('{8'h09, 8'h04, 8'h3a, 8'($random(seed) & 1), v, 8'h04}, 2);
         chk(host_u.got_q[0], wr_result(v));
         chk(host_u.got_q[1], 8'h00);
         chk(demod_sync_window, wr_result(v) == 8'h00 ? v : w);
      end
      frame('{8'h09, 8'h03, 8'h0a, 8'h00, 8'h01}, 2);
      chk(host_u.got_q[0], 8'h00);
      chk({7'h00, sync_assist_filter}, 8'h01);
      protocol_choose_command <= 1'b1;
      @(posedge clk);
      protocol_choose_command <= 1'b0;
      @(posedge clk);
      #1;
      chk(demod_sync_window, 8'h52);
      chk({7'h00, sync_assist_filter}, 8'h00);
      $display("write done");
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      #1;
      chk(baud_divisor, 8'd117);
      $display("reset done");
      conclude();
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      n_errors++;
      conclude();
   end
endmodule
bind hcb_host_cmd hcb_chk chk_u (.clk(clk), .reset_n(reset_n), .rx_data(rx_data),
   .rx_valid(rx_valid), .protocol_choose_command(protocol_choose_command),
   .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .demod_sync_window(demod_sync_window), .sync_assist_filter(sync_assist_filter),
   .baud_divisor(baud_divisor), .bit_tick(bit_tick));
`default_nettype wire
